// File: include/mbsw_pkg.sv
// Shared constants for the serial slave write-function command handler
package mbsw_pkg;
  // Function codes handled here
  localparam logic [7:0] FN_PRESET_ONE = 8'h06;
  localparam logic [7:0] FN_FORCE_COILS = 8'h0F;
  localparam logic [7:0] FN_PRESET_MANY = 8'h10;
  // Exception codes and the flag set in the echoed function byte
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
  localparam logic [7:0] EXC_BUSY = 8'h06;
  localparam logic [7:0] EXC_NAK = 8'h07;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  // Check sequence
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  // Frame layout: byte positions and lengths
  localparam int POS_SLAVE = 0;
  localparam int POS_FUNC = 1;
  localparam int POS_ADDR_HI = 2;
  localparam int POS_ADDR_LO = 3;
  localparam int POS_VAL_HI = 4;
  localparam int POS_VAL_LO = 5;
  localparam int POS_COUNT = 6;
  localparam int POS_DATA = 7;
  localparam logic [7:0] LEN_MIN = 8'h04;
  localparam logic [7:0] LEN_PRESET_ONE = 8'h08;
  localparam logic [8:0] LEN_MULTI_FIXED = 9'h009;
  localparam logic [2:0] ECHO_LEN = 3'h6;
  localparam logic [2:0] EXC_LEN = 3'h3;
  // Quantity limits of the multi-item functions
  localparam logic [15:0] REG_QTY_MAX = 16'h007B;
  localparam logic [15:0] COIL_QTY_MAX = 16'h07B0;
  // Busy window after reset
  localparam int unsigned BUSY_TIME_MS = 3000;
  localparam int unsigned CLK_FREQ_KHZ = 200000;
  localparam int unsigned BUSY_CYCLES = BUSY_TIME_MS * CLK_FREQ_KHZ;
  // Handler states
  typedef enum logic [2:0] {S_RX, S_CHECK, S_EXEC, S_RESP, S_CRC_LO, S_CRC_HI} mbsw_state_t;
endpackage : mbsw_pkg

// File: logic/mbsw_crc16.sv
// Byte-wide CRC-16 accumulator for frame checking and building
`timescale 1ns/1ps
`default_nettype none
module mbsw_crc16
  import mbsw_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Control and data
  input wire logic clear_in,
  input wire logic en_in,
  input wire logic [7:0] byte_in,
  // Running check value
  output logic [15:0] crc_out
);
  logic [15:0] next_crc;

  // Eight reflected shift steps per byte
  always_comb begin
    logic [15:0] c;
    c = crc_out ^ {8'h00, byte_in};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    if (clear_in) begin
      next_crc = CRC_INIT;
    end else if (en_in) begin
      next_crc = c;
    end else begin
      next_crc = crc_out;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      crc_out <= CRC_INIT;
    end else begin
      crc_out <= next_crc;
    end
  end
endmodule : mbsw_crc16
`default_nettype wire

// File: logic/mbsw_busy_timer.sv
// Busy window counter started by reset
`timescale 1ns/1ps
`default_nettype none
module mbsw_busy_timer
  import mbsw_pkg::*;
#(
  parameter int unsigned CYCLES = BUSY_CYCLES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // High until the window has elapsed
  output logic busy_out
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic next_busy;

  // Counter stops once the window ends
  always_comb begin
    next_count = count;
    next_busy = busy_out;
    if (busy_out) begin
      next_count = count + 32'h0000_0001;
      if (next_count >= 32'(CYCLES)) begin
        next_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      count <= 32'h0000_0000;
      busy_out <= 1'b1;
    end else begin
      count <= next_count;
      busy_out <= next_busy;
    end
  end
endmodule : mbsw_busy_timer
`default_nettype wire

// File: logic/mbsw_cmd.sv
// Write-function command handler of a serial RTU slave: frames, checks, writes, answers
// What this block does
// RL1: A single-register preset frame is slave, function, address hi/lo, value hi/lo and a two-byte check.
// RL2: A good single-register preset is answered with slave, function, address and value echoed, then the check.
// RL3: A coil force frame is slave, function, start hi/lo, quantity hi/lo, byte count, coil bytes and a check.
// RL4: A coil force is answered with slave, function, start and quantity echoed and the check, no data.
// RL5: A multi-register preset frame is slave, function, start, count, byte count, hi/lo value pairs and a check.
// RL6: A multi-register preset is answered with slave, function, start and count echoed and the check.
// RL7: An unimplemented function code is answered with exception 01 and nothing is done.
// RL8: An unsupported data address is answered with exception 02 and no state changes.
// RL9: Out-of-range request data is answered with exception 03 and is not applied.
// RL10: For three seconds after reset every valid addressed request gets exception 06 instead.
// RL11: A write into setup memory while write access is off is refused with exception 07.
// RL12: The check is the standard CRC-16 sent low byte first; a bad check or foreign address is dropped silently.
// RL13: An exception answer is slave, function with top bit set, exception code and the check.
`timescale 1ns/1ps
`default_nettype none
module mbsw_cmd
  import mbsw_pkg::*;
#(
  parameter int BUF_DEPTH = 64,
  parameter logic [15:0] NUM_REGS = 16'h0040,
  parameter logic [15:0] SETUP_BASE = 16'h0020,
  parameter logic [15:0] REG_MAX = 16'hFFFF,
  parameter logic [15:0] NUM_COILS = 16'h0010,
  parameter int unsigned BUSY_LEN = BUSY_CYCLES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Configuration
  input wire logic [7:0] slave_addr_in,
  input wire logic setup_wr_en_in,
  // Received frame bytes
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  input wire logic rx_end_in,
  // Answer bytes
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  // Register write strobe
  output logic reg_wr_out,
  output logic [15:0] reg_addr_out,
  output logic [15:0] reg_data_out,
  // Coil write strobe
  output logic coil_wr_out,
  output logic [15:0] coil_addr_out,
  output logic coil_val_out,
  // Busy window indicator
  output logic busy_out
);
  localparam int BW = $clog2(BUF_DEPTH);

  mbsw_state_t state, next_state;
  logic [7:0] frame [BUF_DEPTH];
  logic [7:0] next_frame [BUF_DEPTH];
  logic [7:0] len, next_len;
  logic ovf, next_ovf;
  logic [15:0] idx, next_idx;
  logic [7:0] exc, next_exc;
  logic [2:0] tidx, next_tidx;
  logic [7:0] next_tx_byte;
  logic next_tx_valid;
  logic next_reg_wr, next_coil_wr, next_coil_val;
  logic [15:0] next_reg_addr, next_reg_data, next_coil_addr;
  logic crc_clear, rx_take, tx_take;
  logic [15:0] rx_crc, tx_crc;
  logic busy;

  // Frame fields
  logic [7:0] func, bcount;
  logic [15:0] start, val, last_idx;
  logic [16:0] span;
  logic [8:0] want_len;
  logic [7:0] decide;
  logic [2:0] resp_len;

  // Check over the whole received frame, check bytes included
  mbsw_crc16 u_rx_crc (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(crc_clear),
    .en_in(rx_take),
    .byte_in(rx_byte_in),
    .crc_out(rx_crc)
  );

  // Check over the answer bytes before the check itself
  mbsw_crc16 u_tx_crc (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(crc_clear),
    .en_in(tx_take && state == S_RESP),
    .byte_in(tx_byte_out),
    .crc_out(tx_crc)
  );

  mbsw_busy_timer #(
    .CYCLES(BUSY_LEN)
  ) u_busy (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .busy_out(busy)
  );

  assign busy_out = busy;
  assign rx_take = (state == S_RX) && rx_valid_in;
  assign tx_take = tx_valid_out && tx_ready_in;

  // RL1: field positions
  // RL3: quantity and byte count
  // RL5: pairs follow count
  always_comb begin
    func = frame[POS_FUNC];
    start = {frame[POS_ADDR_HI], frame[POS_ADDR_LO]};
    val = {frame[POS_VAL_HI], frame[POS_VAL_LO]};
    bcount = frame[POS_COUNT];
    span = {1'b0, start} + {1'b0, val};
    want_len = LEN_MULTI_FIXED + {1'b0, bcount};
    last_idx = (func == FN_PRESET_ONE) ? 16'h0000 : val - 16'h0001;
    resp_len = (exc != EXC_NONE) ? EXC_LEN : ECHO_LEN;
  end

  // Exception decision, busy first, then function, value, address, protection
  always_comb begin
    decide = EXC_NONE;
    if (busy) begin
      // RL10: busy answer
      decide = EXC_BUSY;
    end else begin
      case (func)
        FN_PRESET_ONE: begin
          // RL9: frame length and value range
          if (len != LEN_PRESET_ONE || val > REG_MAX) begin
            decide = EXC_ILL_VALUE;
          // RL8: register address
          end else if (start >= NUM_REGS) begin
            decide = EXC_ILL_ADDR;
          // RL11: setup area locked
          end else if (start >= SETUP_BASE && !setup_wr_en_in) begin
            decide = EXC_NAK;
          end
        end
        FN_FORCE_COILS: begin
          // RL9: coil quantity and count
          if (val == 16'h0000 || val > COIL_QTY_MAX || ovf || {1'b0, len} != want_len ||
              {8'h00, bcount} != 16'((val + 16'h0007) >> 3)) begin
            decide = EXC_ILL_VALUE;
          // RL8: coil range
          end else if (span > {1'b0, NUM_COILS}) begin
            decide = EXC_ILL_ADDR;
          end
        end
        FN_PRESET_MANY: begin
          // RL9: register count and count
          if (val == 16'h0000 || val > REG_QTY_MAX || ovf || {1'b0, len} != want_len ||
              {8'h00, bcount} != {val[14:0], 1'b0}) begin
            decide = EXC_ILL_VALUE;
          // RL8: register range
          end else if (span > {1'b0, NUM_REGS}) begin
            decide = EXC_ILL_ADDR;
          // RL11: any target in setup area
          end else if (span > {1'b0, SETUP_BASE} && !setup_wr_en_in) begin
            decide = EXC_NAK;
          end
        end
        // RL7: unknown function
        default: decide = EXC_ILL_FUNC;
      endcase
    end
  end

  // Answer byte by position
  function automatic logic [7:0] resp_byte(input logic [2:0] i, input logic [7:0] code,
                                           input logic [7:0] b0, input logic [7:0] b1,
                                           input logic [7:0] b2, input logic [7:0] b3,
                                           input logic [7:0] b4, input logic [7:0] b5);
    logic [7:0] r;
    r = b0;
    if (code != EXC_NONE) begin
      // RL13: slave, flagged function, code
      case (i)
        3'h0: r = b0;
        3'h1: r = b1 | EXC_FLAG;
        default: r = code;
      endcase
    end else begin
      // RL2: echo address and value
      // RL4: echo start and quantity
      // RL6: echo start and count
      case (i)
        3'h0: r = b0;
        3'h1: r = b1;
        3'h2: r = b2;
        3'h3: r = b3;
        3'h4: r = b4;
        default: r = b5;
      endcase
    end
    return r;
  endfunction : resp_byte

  // Main sequencer; strobes and answer bytes computed here, registered below
  always_comb begin
    logic [15:0] pos;
    logic [7:0] cbyte;
    pos = 16'h0000;
    cbyte = 8'h00;
    next_state = state;
    next_frame = frame;
    next_len = len;
    next_ovf = ovf;
    next_idx = idx;
    next_exc = exc;
    next_tidx = tidx;
    next_tx_byte = tx_byte_out;
    next_tx_valid = tx_valid_out;
    next_reg_wr = 1'b0;
    next_coil_wr = 1'b0;
    next_reg_addr = reg_addr_out;
    next_reg_data = reg_data_out;
    next_coil_addr = coil_addr_out;
    next_coil_val = coil_val_out;
    crc_clear = 1'b0;
    case (state)
      S_RX: begin
        // Bytes past the buffer still feed the check; too long shows as a value error
        if (rx_take) begin
          if (len < 8'(BUF_DEPTH)) begin
            next_frame[len[BW-1:0]] = rx_byte_in;
          end else begin
            next_ovf = 1'b1;
          end
          if (len != 8'hFF) begin
            next_len = len + 8'h01;
          end
        end
        if (rx_end_in) begin
          next_state = S_CHECK;
        end
      end
      S_CHECK: begin
        // RL12: drop on bad check or other slave
        if (len < LEN_MIN || rx_crc != 16'h0000 || frame[POS_SLAVE] != slave_addr_in) begin
          next_state = S_RX;
          crc_clear = 1'b1;
        end else begin
          next_exc = decide;
          next_idx = 16'h0000;
          next_state = (decide == EXC_NONE) ? S_EXEC : S_RESP;
          if (decide != EXC_NONE) begin
            next_tidx = 3'h0;
            next_tx_valid = 1'b1;
            next_tx_byte = resp_byte(3'h0, decide, frame[0], frame[1], frame[2], frame[3], frame[4], frame[5]);
          end
        end
      end
      S_EXEC: begin
        // One write strobe per cycle, item by item
        if (func == FN_FORCE_COILS) begin
          pos = 16'(POS_DATA) + {3'h0, idx[15:3]};
          cbyte = frame[pos[BW-1:0]];
          next_coil_wr = 1'b1;
          next_coil_addr = start + idx;
          next_coil_val = cbyte[idx[2:0]];
        end else if (func == FN_PRESET_MANY) begin
          pos = 16'(POS_DATA) + {idx[14:0], 1'b0};
          next_reg_wr = 1'b1;
          next_reg_addr = start + idx;
          next_reg_data = {frame[pos[BW-1:0]], frame[pos[BW-1:0] + BW'(1)]};
        end else begin
          next_reg_wr = 1'b1;
          next_reg_addr = start;
          next_reg_data = val;
        end
        next_idx = idx + 16'h0001;
        if (idx == last_idx) begin
          next_state = S_RESP;
          next_tidx = 3'h0;
          next_tx_valid = 1'b1;
          next_tx_byte = resp_byte(3'h0, exc, frame[0], frame[1], frame[2], frame[3], frame[4], frame[5]);
        end
      end
      S_RESP: begin
        if (tx_take) begin
          next_tidx = tidx + 3'h1;
          if (tidx == resp_len - 3'h1) begin
            // Gap of one cycle lets the check absorb the last byte
            next_tx_valid = 1'b0;
            next_state = S_CRC_LO;
          end else begin
            next_tx_byte = resp_byte(tidx + 3'h1, exc, frame[0], frame[1], frame[2], frame[3], frame[4], frame[5]);
          end
        end
      end
      S_CRC_LO: begin
        // RL12: low check byte first
        if (!tx_valid_out) begin
          next_tx_valid = 1'b1;
          next_tx_byte = tx_crc[7:0];
        end else if (tx_take) begin
          next_tx_byte = tx_crc[15:8];
          next_state = S_CRC_HI;
        end
      end
      S_CRC_HI: begin
        if (tx_take) begin
          next_tx_valid = 1'b0;
          next_state = S_RX;
          crc_clear = 1'b1;
        end
      end
      default: begin
        next_state = S_RX;
        crc_clear = 1'b1;
      end
    endcase
    // New frame starts from an empty buffer
    if (crc_clear) begin
      next_len = 8'h00;
      next_ovf = 1'b0;
    end
  end

  // State and output registers
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state <= S_RX;
      len <= 8'h00;
      ovf <= 1'b0;
      idx <= 16'h0000;
      exc <= EXC_NONE;
      tidx <= 3'h0;
      tx_byte_out <= 8'h00;
      tx_valid_out <= 1'b0;
      reg_wr_out <= 1'b0;
      reg_addr_out <= 16'h0000;
      reg_data_out <= 16'h0000;
      coil_wr_out <= 1'b0;
      coil_addr_out <= 16'h0000;
      coil_val_out <= 1'b0;
    end else begin
      state <= next_state;
      len <= next_len;
      ovf <= next_ovf;
      idx <= next_idx;
      exc <= next_exc;
      tidx <= next_tidx;
      tx_byte_out <= next_tx_byte;
      tx_valid_out <= next_tx_valid;
      reg_wr_out <= next_reg_wr;
      reg_addr_out <= next_reg_addr;
      reg_data_out <= next_reg_data;
      coil_wr_out <= next_coil_wr;
      coil_addr_out <= next_coil_addr;
      coil_val_out <= next_coil_val;
    end
  end

  // Frame buffer, no reset needed: length gates every read
  always_ff @(posedge mclk_in) begin
    frame <= next_frame;
  end
endmodule : mbsw_cmd
`default_nettype wire

// File: tb/mbsw_cmd_props.sv
// Port-level assertion checker for the write-function command handler
`timescale 1ns/1ps
`default_nettype none
module mbsw_cmd_props #(
  parameter int unsigned BUSY_LEN = 20
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Answer side
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  // Write strobes and busy flag
  input wire logic reg_wr_out,
  input wire logic [15:0] reg_addr_out,
  input wire logic [15:0] reg_data_out,
  input wire logic coil_wr_out,
  input wire logic [15:0] coil_addr_out,
  input wire logic busy_out
);
  int unsigned cnt;
  int unsigned next_cnt;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // Cycles since reset release, saturating so it never wraps
  always_comb begin
    next_cnt = cnt;
    if (cnt <= BUSY_LEN) next_cnt = cnt + 1;
  end
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) cnt <= 0;
    else cnt <= next_cnt;
  end
  AST_BUSY_RST: assert property ($past(sys_rst_in) |-> busy_out && !tx_valid_out) else $error("not idle busy after reset");
  AST_BUSY_HI: assert property ((cnt < BUSY_LEN) |-> busy_out) else $error("busy ended early");
  AST_BUSY_LO: assert property ((cnt >= BUSY_LEN) |-> !busy_out) else $error("busy ended late");
  AST_BUSY_NOWR: assert property (busy_out |-> !(reg_wr_out || coil_wr_out)) else $error("write while busy");
  AST_TX_HOLD: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
    else $error("answer byte dropped");
  // writes precede answer; the first answer byte may rise with the last strobe
  AST_WR_EXCL: assert property ((reg_wr_out || coil_wr_out) |-> !(reg_wr_out && coil_wr_out) && !$past(tx_valid_out))
    else $error("write overlaps");
  AST_REG_STEP: assert property (reg_wr_out && $past(reg_wr_out) |-> reg_addr_out == $past(reg_addr_out) + 16'h0001)
    else $error("register address not stepping");
  AST_COIL_STEP: assert property (coil_wr_out && $past(coil_wr_out) |-> coil_addr_out == $past(coil_addr_out) + 16'h0001)
    else $error("coil address not stepping");
  AST_ADDR_KEEP: assert property (!$past(sys_rst_in) && !reg_wr_out |-> $stable(reg_addr_out) && $stable(reg_data_out))
    else $error("register bus moved without write");
endmodule : mbsw_cmd_props
`default_nettype wire

// File: tb/mbsw_host_model.sv
// Master host model: sends request frames and takes answer bytes
`timescale 1ns/1ps
`default_nettype none
module mbsw_host_model (
  // Clock
  input wire logic mclk_in,
  // Request bytes toward the slave
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  output logic rx_end_out,
  // Answer bytes from the slave
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out
);
  logic [7:0] got[$];
  int slow = 0;
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_end_out = 1'b0;
    tx_ready_out = 1'b1;
  end
  // capture answer, stall at random in slow mode
  always @(posedge mclk_in) begin
    if (tx_valid_in && tx_ready_out) got.push_back(tx_byte_in);
    #1 tx_ready_out = (slow == 0) || ($urandom_range(0, 1) == 1);
  end
  // bytes back to back, end on last
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(posedge mclk_in);
      #1;
      rx_byte_out = f[i];
      rx_valid_out = 1'b1;
      rx_end_out = (i == f.size() - 1);
    end
    @(posedge mclk_in);
    #1;
    rx_byte_out = ~rx_byte_out; // Idle line never shows stale data
    rx_valid_out = 1'b0;
    rx_end_out = 1'b0;
  endtask : send
endmodule : mbsw_host_model
`default_nettype wire

// File: tb/test_modbus_slave_write_functions.sv
// Testbench: frames in, answers and writes compared with a bench model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_modbus_slave_write_functions;
  import mbsw_pkg::*;
  localparam int unsigned BLEN = 20;
  localparam logic [7:0] ME = 8'h11;
  localparam logic [15:0] NREG = 16'h0040;
  localparam logic [15:0] SBASE = 16'h0020;
  localparam logic [15:0] NCOIL = 16'h0010;
  logic mclk_in, sys_rst_in, setup_wr_en_in, rx_valid_in, rx_end_in, tx_ready_in;
  logic tx_valid_out, reg_wr_out, coil_wr_out, coil_val_out, busy_out;
  logic [7:0] rx_byte_in, tx_byte_out;
  logic [15:0] reg_addr_out, reg_data_out, coil_addr_out;
  logic [32:0] wr_q[$], exp_w[$];
  int fails = 0;
  int compares = 0;
  mbsw_cmd #(.NUM_REGS(NREG), .SETUP_BASE(SBASE), .NUM_COILS(NCOIL), .BUSY_LEN(BLEN)) u_dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .slave_addr_in(ME), .setup_wr_en_in(setup_wr_en_in),
    .rx_byte_in(rx_byte_in), .rx_valid_in(rx_valid_in), .rx_end_in(rx_end_in), .tx_byte_out(tx_byte_out),
    .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .reg_wr_out(reg_wr_out),
    .reg_addr_out(reg_addr_out), .reg_data_out(reg_data_out), .coil_wr_out(coil_wr_out),
    .coil_addr_out(coil_addr_out), .coil_val_out(coil_val_out), .busy_out(busy_out));
  mbsw_host_model u_host (.mclk_in(mclk_in), .rx_byte_out(rx_byte_in), .rx_valid_out(rx_valid_in),
    .rx_end_out(rx_end_in), .tx_byte_in(tx_byte_out), .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in));
  // Clock at 200 MHz
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  // Log every write strobe the slave issues
  always @(posedge mclk_in) begin
    if (reg_wr_out === 1'b1) wr_q.push_back({1'b0, reg_addr_out, reg_data_out});
    if (coil_wr_out === 1'b1) wr_q.push_back({1'b1, coil_addr_out, 15'h0000, coil_val_out});
  end
  // reflected check, low byte sent first
  function automatic logic [15:0] crc(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc
  // Bench model: exception code by priority, expected writes queued
  function automatic logic [7:0] model(input logic [7:0] f[$], input logic busy);
    logic [7:0] fn;
    int a, n, len;
    fn = f[1];
    a = {f[2], f[3]};
    n = {f[4], f[5]};
    len = f.size();
    if (busy) return EXC_BUSY;
    if (fn == FN_PRESET_ONE) begin
      if (len != 8) return EXC_ILL_VALUE;
      if (a >= NREG) return EXC_ILL_ADDR;
      if (a >= SBASE && !setup_wr_en_in) return EXC_NAK;
      exp_w.push_back({1'b0, f[2], f[3], f[4], f[5]});
    end else if (fn == FN_PRESET_MANY) begin
      if (n == 0 || n > REG_QTY_MAX || f[6] != 2 * n || len != 9 + 2 * n) return EXC_ILL_VALUE;
      if (a + n > NREG) return EXC_ILL_ADDR;
      if (a + n > SBASE && !setup_wr_en_in) return EXC_NAK;
      for (int i = 0; i < n; i++) exp_w.push_back({1'b0, 16'(a + i), f[7 + 2 * i], f[8 + 2 * i]});
    end else if (fn == FN_FORCE_COILS) begin
      if (n == 0 || n > COIL_QTY_MAX || f[6] != (n + 7) / 8 || len != 9 + f[6]) return EXC_ILL_VALUE;
      if (a + n > NCOIL) return EXC_ILL_ADDR;
      for (int i = 0; i < n; i++) exp_w.push_back({1'b1, 16'(a + i), 15'h0000, f[7 + i / 8][i % 8]});
    end else return EXC_ILL_FUNC;
    return EXC_NONE;
  endfunction : model
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // Send one frame, then compare answer bytes and writes with the model
  task automatic run(input string nm, input logic [7:0] f[$], input logic busy, input logic good);
    logic [7:0] e[$];
    logic [7:0] x;
    logic [15:0] c;
    int k;
    c = crc(f);
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    exp_w.delete();
    if (good && f[0] == ME) begin
      x = model(f, busy);
      if (x == EXC_NONE) e = f[0:5];
      else e = '{f[0], f[1] | EXC_FLAG, x};
      c = crc(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end else f[f.size() - 1] = f[f.size() - 1] ^ {7'h00, !good};
    wr_q.delete();
    u_host.got.delete();
    u_host.send(f);
    k = 0;
    while (u_host.got.size() < e.size() && k < 400) begin
      @(posedge mclk_in);
      k++;
    end
    if (k == 400) begin
      `CHK(nm, 1, 0)
      conclude();
    end
    repeat (30) @(posedge mclk_in);
    `CHK(nm, e.size(), u_host.got.size())
    foreach (e[i]) if (i < u_host.got.size()) `CHK(nm, e[i], u_host.got[i])
    `CHK(nm, exp_w.size(), wr_q.size())
    foreach (exp_w[i]) if (i < wr_q.size()) `CHK(nm, exp_w[i], wr_q[i])
    $display("test %s done", nm);
  endtask : run
  task automatic do_reset();
    // Raised off the edge so the design never races the bench
    #1 sys_rst_in = 1'b1;
    repeat (5) @(posedge mclk_in);
    #1 sys_rst_in = 1'b0;
  endtask : do_reset
  initial begin
    logic [7:0] d[$];
    logic [7:0] codes[3];
    int k;
    sys_rst_in = 1'b1;
    setup_wr_en_in = 1'b1;
    codes = '{8'h05, 8'h2B, 8'h03};
    k = $urandom(16);
    do_reset();
    run("busy", '{ME, FN_PRESET_ONE, 8'h00, 8'h05, 8'h12, 8'h34}, 1'b1, 1'b1);
    k = 0;
    while (busy_out !== 1'b0 && k < 100) begin
      @(posedge mclk_in);
      k++;
    end
    `CHK("busy_end", 1, k < 100)
    if (k >= 100) conclude();
    d = '{ME, FN_PRESET_ONE, 8'h00, 8'($urandom_range(0, 31)), 8'($urandom), 8'($urandom)};
    run("one", d, 1'b0, 1'b1);
    u_host.slow = 1;
    d = '{ME, FN_PRESET_MANY, 8'h00, 8'h3D, 8'h00, 8'h03, 8'h06};
    repeat (6) d.push_back(8'($urandom));
    run("many", d, 1'b0, 1'b1);
    run("coil", '{ME, FN_FORCE_COILS, 8'h00, 8'h02, 8'h00, 8'h0A, 8'h02, 8'($urandom), 8'($urandom)},
      1'b0, 1'b1);
    u_host.slow = 0;
    foreach (codes[i]) run("func", '{ME, codes[i], 8'h00, 8'h01, 8'h00, 8'h01}, 1'b0, 1'b1);
    run("addr1", '{ME, FN_PRESET_ONE, 8'h00, 8'h40, 8'h00, 8'h01}, 1'b0, 1'b1);
    run("addr2", '{ME, FN_PRESET_MANY, 8'h00, 8'h3F, 8'h00, 8'h02, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04},
      1'b0, 1'b1);
    run("val1", '{ME, FN_PRESET_MANY, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00}, 1'b0, 1'b1);
    run("val2", '{ME, FN_PRESET_ONE, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00}, 1'b0, 1'b1);
    #1 setup_wr_en_in = 1'b0;
    run("nak1", '{ME, FN_PRESET_ONE, 8'h00, 8'h20, 8'h00, 8'h01}, 1'b0, 1'b1);
    run("nak2", '{ME, FN_PRESET_MANY, 8'h00, 8'h1F, 8'h00, 8'h02, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04},
      1'b0, 1'b1);
    run("crc", '{ME, FN_PRESET_ONE, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b0, 1'b0);
    run("other", '{ME + 8'h01, FN_PRESET_ONE, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b0, 1'b1);
    do_reset();
    run("busy2", '{ME, FN_FORCE_COILS, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01}, 1'b1, 1'b1);
    conclude();
  end
endmodule : test_modbus_slave_write_functions
bind mbsw_cmd mbsw_cmd_props #(.BUSY_LEN(BUSY_LEN)) u_props (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .tx_byte_out(tx_byte_out), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .reg_wr_out(reg_wr_out),
  .reg_addr_out(reg_addr_out), .reg_data_out(reg_data_out), .coil_wr_out(coil_wr_out),
  .coil_addr_out(coil_addr_out), .busy_out(busy_out));
`undef CHK
`default_nettype wire
